// ### tx_icp_regs_pkg.sv
// constants for the transmit control-cell flag and fifo length register bank
// Notes on behaviour
// - writing 0 arms a group flag; it reads 0 until a reference-link control cell goes out
// - writing 1 to a frame flag changes neither the flag nor its detection state
// - frame flags sit in bits 7:0, upper byte reads zero, reset value 00FF
// - transfer interrupt enable per group gates transfer-completion interrupts, resets to zero
// - frame interrupt enable per group gates frame indication interrupts, resets to zero
// - eight link length registers, link N in bits 3:0, link N+8 in bits 11:8
// - length registers read zero in 15:12; software writes zero to bits 7:4
// - four group length registers, group N low, group N+4 high, reset 0101
// - status read returns selected length, free in 6:0, others in 4:0, rest zero
// - transfer trigger bit reads 1 when transfer completes; that completion drives the interrupt
package tx_icp_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int GROUPS = 8;
  localparam int LINKS = 16;
  localparam int LEN_W = 4;
  localparam int FILL_W = 5;
  localparam int FREE_W = 7;
  localparam int HI_LSB = 8;
  localparam int LINK_REGS = 8;
  localparam int GROUP_REGS = 4;
  localparam logic [7:0] FRAME_FLAGS_ADDR = 8'h87;
  localparam logic [7:0] XFER_IRQ_EN_ADDR = 8'h88;
  localparam logic [7:0] FRAME_IRQ_EN_ADDR = 8'h89;
  localparam logic [7:0] LINK_LEN_BASE = 8'h8B;
  localparam logic [7:0] GROUP_LEN_BASE = 8'h93;
  localparam logic [7:0] LEN_STATUS_ADDR = 8'h9B;
  localparam logic [7:0] FRAME_FLAGS_RESET = 8'hFF;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [11:0] LINK_LEN_RESET = 12'h000;
  localparam logic [11:0] GROUP_LEN_RESET = 12'h101;
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [5:0] SEL_FREE = 6'h18;
endpackage

// ### tx_icp_frame_fifo_regs.sv
// transmit control-cell flags, interrupt enables and fifo length registers
`timescale 1ns/100ps
module tx_icp_frame_fifo_regs #(
  parameter int NUM_GROUPS = 8
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  input wire logic [7:0] xfer_done_i,
  input wire logic [7:0] ref_icp_sent_i,
  input wire logic [79:0] link_fifo_fill_i,
  input wire logic [39:0] group_fifo_fill_i,
  input wire logic [6:0] free_fifo_fill_i,
  input wire logic [79:0] mod_len_i,
  output logic [5:0] fifo_sel_o,
  output logic [63:0] link_fifo_len_o,
  output logic [31:0] group_fifo_len_o,
  output logic irq_o
);
  if (NUM_GROUPS < 1 || NUM_GROUPS > tx_icp_regs_pkg::GROUPS) begin : g_bad_groups
    $error("NUM_GROUPS must be 1 to 8");
  end

  // groups beyond NUM_GROUPS stay at reset and never interrupt
  localparam logic [8:0] GROUP_MASK9 = (9'h001 << NUM_GROUPS) - 9'h001;
  localparam logic [7:0] GROUP_MASK = GROUP_MASK9[7:0];

  logic [7:0] frame_flags, next_frame_flags;
  logic [7:0] frame_seen, next_frame_seen;
  logic [7:0] xfer_en, next_xfer_en;
  logic [7:0] frame_en, next_frame_en;
  logic [11:0] link_len [tx_icp_regs_pkg::LINK_REGS];
  logic [11:0] next_link_len [tx_icp_regs_pkg::LINK_REGS];
  logic [11:0] group_len [tx_icp_regs_pkg::GROUP_REGS];
  logic [11:0] next_group_len [tx_icp_regs_pkg::GROUP_REGS];
  logic [5:0] fifo_sel, next_fifo_sel;
  logic [15:0] next_rdata;
  logic [6:0] sel_len;
  logic next_irq;
  logic [7:0] link_off, group_off;
  logic [7:0] wdata_low;
  logic [3:0] wdata_nib;

  assign link_off = addr_i - tx_icp_regs_pkg::LINK_LEN_BASE;
  assign group_off = addr_i - tx_icp_regs_pkg::GROUP_LEN_BASE;
  assign wdata_low = wdata_i[7:0];
  assign wdata_nib = wdata_i[3:0];
  assign fifo_sel_o = fifo_sel;

  // per-entry length outputs, passed through untouched
  for (genvar n = 0; n < tx_icp_regs_pkg::LINK_REGS; n++) begin : g_link
    assign link_fifo_len_o[n*4 +: 4] = link_len[n][3:0];
    assign link_fifo_len_o[(n+8)*4 +: 4] = link_len[n][11:8];
  end
  for (genvar n = 0; n < tx_icp_regs_pkg::GROUP_REGS; n++) begin : g_group
    assign group_fifo_len_o[n*4 +: 4] = group_len[n][3:0];
    assign group_fifo_len_o[(n+4)*4 +: 4] = group_len[n][11:8];
  end

  // frame flags: arming clears, a reference-link cell sets; set wins over clear
  always_comb begin
    next_frame_flags = frame_flags;
    next_frame_seen = frame_seen;
    for (int g = 0; g < tx_icp_regs_pkg::GROUPS; g++) begin
      if (wr_i && addr_i == tx_icp_regs_pkg::FRAME_FLAGS_ADDR && !wdata_i[g]) begin
        next_frame_flags[g] = 1'b0; // a written 1 leaves both bits alone
        next_frame_seen[g] = 1'b0;
      end
      // a cell sent in the arming cycle still counts, so the set beats the clear
      if (ref_icp_sent_i[g] && !next_frame_flags[g]) begin
        next_frame_flags[g] = 1'b1;
        next_frame_seen[g] = 1'b1;
      end
    end
    next_frame_flags = (next_frame_flags & GROUP_MASK) | ~GROUP_MASK;
    next_frame_seen = next_frame_seen & GROUP_MASK;
  end

  // control registers
  always_comb begin
    next_xfer_en = xfer_en;
    next_frame_en = frame_en;
    next_fifo_sel = fifo_sel;
    next_link_len = link_len;
    next_group_len = group_len;
    if (wr_i) begin
      if (addr_i == tx_icp_regs_pkg::XFER_IRQ_EN_ADDR) begin
        next_xfer_en = wdata_low & GROUP_MASK;
      end
      if (addr_i == tx_icp_regs_pkg::FRAME_IRQ_EN_ADDR) begin
        next_frame_en = wdata_low & GROUP_MASK;
      end
      if (addr_i == tx_icp_regs_pkg::LEN_STATUS_ADDR) begin
        next_fifo_sel = wdata_i[5:0];
      end
      if (link_off < 8'(tx_icp_regs_pkg::LINK_REGS)) begin
        next_link_len[link_off[2:0]] = wdata_i[11:0];
      end
      if (group_off < 8'(tx_icp_regs_pkg::GROUP_REGS)) begin
        next_group_len[group_off[1:0]] = wdata_i[11:0];
      end
    end
  end

  // indirect status: decode the selection code into a length
  always_comb begin
    sel_len = 7'h00;
    if (fifo_sel[5:4] == 2'b00) begin
      sel_len = {2'b00, link_fifo_fill_i[fifo_sel[3:0]*5 +: 5]};
    end else if (fifo_sel[5:3] == 3'b010) begin
      sel_len = {2'b00, group_fifo_fill_i[fifo_sel[2:0]*5 +: 5]};
    end else if (fifo_sel == tx_icp_regs_pkg::SEL_FREE) begin
      sel_len = free_fifo_fill_i;
    end else if (fifo_sel[5:4] == 2'b10) begin
      sel_len = {2'b00, mod_len_i[fifo_sel[3:0]*5 +: 5]};
    end
  end

  // read data is registered; unmapped addresses read zero
  always_comb begin
    next_rdata = rdata_o;
    if (rd_i) begin
      next_rdata = 16'h0000;
      if (addr_i == tx_icp_regs_pkg::FRAME_FLAGS_ADDR) begin
        next_rdata = {8'h00, frame_flags};
      end else if (addr_i == tx_icp_regs_pkg::XFER_IRQ_EN_ADDR) begin
        next_rdata = {8'h00, xfer_en};
      end else if (addr_i == tx_icp_regs_pkg::FRAME_IRQ_EN_ADDR) begin
        next_rdata = {8'h00, frame_en};
      end else if (addr_i == tx_icp_regs_pkg::LEN_STATUS_ADDR) begin
        next_rdata = {9'h000, sel_len};
      end else if (link_off < 8'(tx_icp_regs_pkg::LINK_REGS)) begin
        next_rdata = {4'h0, link_len[link_off[2:0]]};
      end else if (group_off < 8'(tx_icp_regs_pkg::GROUP_REGS)) begin
        next_rdata = {4'h0, group_len[group_off[1:0]]};
      end
    end
  end

  // one level request; completion level comes from the trigger register logic
  always_comb begin
    next_irq = |(xfer_done_i & xfer_en) | |(frame_seen & frame_en);
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_flags <= tx_icp_regs_pkg::FRAME_FLAGS_RESET;
      frame_seen <= 8'h00;
      xfer_en <= tx_icp_regs_pkg::IRQ_EN_RESET;
      frame_en <= tx_icp_regs_pkg::IRQ_EN_RESET;
      fifo_sel <= tx_icp_regs_pkg::SEL_RESET;
      link_len <= '{default: tx_icp_regs_pkg::LINK_LEN_RESET};
      group_len <= '{default: tx_icp_regs_pkg::GROUP_LEN_RESET};
      rdata_o <= 16'h0000;
      irq_o <= 1'b0;
    end else begin
      frame_flags <= next_frame_flags;
      frame_seen <= next_frame_seen;
      xfer_en <= next_xfer_en;
      frame_en <= next_frame_en;
      fifo_sel <= next_fifo_sel;
      link_len <= next_link_len;
      group_len <= next_group_len;
      rdata_o <= next_rdata;
      irq_o <= next_irq;
    end
  end

  upper_byte_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rd_i && addr_i == tx_icp_regs_pkg::FRAME_FLAGS_ADDR |=> rdata_o[15:8] == 8'h00)
    else $error("frame flag upper byte not zero");
  frame_arm_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_i && addr_i == tx_icp_regs_pkg::FRAME_FLAGS_ADDR && ref_icp_sent_i == 8'h00
    |=> (frame_flags & ~$past(wdata_low) & GROUP_MASK) == 8'h00)
    else $error("written zero did not arm flag");
  write_one_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_i && addr_i == tx_icp_regs_pkg::FRAME_FLAGS_ADDR && wdata_low == 8'hFF
    && ref_icp_sent_i == 8'h00 |=> $stable(frame_flags) && $stable(frame_seen))
    else $error("writing one changed a flag");
  cell_sets_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    |(ref_icp_sent_i & ~frame_flags)
    |=> (frame_flags & $past(ref_icp_sent_i & ~frame_flags)) == $past(ref_icp_sent_i & ~frame_flags))
    else $error("sent cell did not set flag");
  set_wins_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_i && addr_i == tx_icp_regs_pkg::FRAME_FLAGS_ADDR && |(ref_icp_sent_i & ~wdata_low & GROUP_MASK)
    |=> (frame_flags & $past(ref_icp_sent_i & ~wdata_low & GROUP_MASK))
    == $past(ref_icp_sent_i & ~wdata_low & GROUP_MASK))
    else $error("cell in arming cycle was lost");
  irq_raise_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    |(xfer_done_i & xfer_en) || |(frame_seen & frame_en) |=> irq_o)
    else $error("enabled event gave no interrupt");
  irq_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (xfer_done_i & xfer_en) == 8'h00 && (frame_seen & frame_en) == 8'h00 |=> !irq_o)
    else $error("interrupt without enabled event");
  len_upper_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rd_i && group_off < 8'h04 |=> rdata_o[15:12] == 4'h0)
    else $error("length register top nibble not zero");
  status_upper_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rd_i && addr_i == tx_icp_regs_pkg::LEN_STATUS_ADDR |=> rdata_o[15:7] == 9'h000)
    else $error("status upper bits not zero");
  link_pass_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_i && addr_i == tx_icp_regs_pkg::LINK_LEN_BASE
    |=> link_fifo_len_o[3:0] == $past(wdata_nib))
    else $error("link 0 length not passed on");
  link_high_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_i && addr_i == tx_icp_regs_pkg::LINK_LEN_BASE |=> link_fifo_len_o[35:32] == $past(wdata_i[11:8]))
    else $error("link 8 length not passed on");
  group_pass_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_i && addr_i == tx_icp_regs_pkg::GROUP_LEN_BASE |=> group_fifo_len_o[3:0] == $past(wdata_nib))
    else $error("group 0 length not passed on");
  status_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_i && addr_i == tx_icp_regs_pkg::LEN_STATUS_ADDR |=> fifo_sel_o == $past(wdata_i[5:0]))
    else $error("status selection not taken");
  free_status_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rd_i && addr_i == tx_icp_regs_pkg::LEN_STATUS_ADDR && fifo_sel == tx_icp_regs_pkg::SEL_FREE
    |=> rdata_o == {9'h000, $past(free_fifo_fill_i)})
    else $error("free cell length misreported");
  link_status_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rd_i && addr_i == tx_icp_regs_pkg::LEN_STATUS_ADDR && fifo_sel == 6'h00
    |=> rdata_o == {11'h000, $past(link_fifo_fill_i[4:0])})
    else $error("link 0 length misreported");
  mod_status_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rd_i && addr_i == tx_icp_regs_pkg::LEN_STATUS_ADDR && fifo_sel[5:4] == 2'b10
    |=> rdata_o[15:5] == 11'h000)
    else $error("modifier length upper bits not zero");
endmodule

// ### tx_icp_frame_fifo_regs_tb.sv
// self-checking bench for the transmit flag, enable and fifo length register bank
`timescale 1ns/100ps
module tx_icp_frame_fifo_regs_tb;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  logic [7:0] xfer_done_i = 8'h00;
  logic [7:0] ref_icp_sent_i = 8'h00;
  logic [79:0] link_fifo_fill_i;
  logic [39:0] group_fifo_fill_i;
  logic [6:0] free_fifo_fill_i = 7'h55;
  logic [79:0] mod_len_i;
  logic [5:0] fifo_sel_o;
  logic [63:0] link_fifo_len_o;
  logic [31:0] group_fifo_len_o;
  logic irq_o;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  tx_icp_frame_fifo_regs u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .xfer_done_i(xfer_done_i),
    .ref_icp_sent_i(ref_icp_sent_i), .link_fifo_fill_i(link_fifo_fill_i),
    .group_fifo_fill_i(group_fifo_fill_i), .free_fifo_fill_i(free_fifo_fill_i),
    .mod_len_i(mod_len_i), .fifo_sel_o(fifo_sel_o), .link_fifo_len_o(link_fifo_len_o),
    .group_fifo_len_o(group_fifo_len_o), .irq_o(irq_o));
  always #50 sys_clk_i = ~sys_clk_i;
  // fill patterns differ within each fifo kind; link 15, group 0 and modifier 15 all hold 16
  initial begin
    for (int k = 0; k < 16; k++) begin
      link_fifo_fill_i[5*k +: 5] = 5'(k + 1);
      mod_len_i[5*k +: 5] = 5'(31 - k);
    end
    for (int g = 0; g < 8; g++) group_fifo_fill_i[5*g +: 5] = 5'(g + 16);
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    d = rdata_o;
  endtask
  task automatic reset_values();
    logic [15:0] d;
    rd(8'h87, d); chk("frame flags", d, 16'h00FF);
    rd(8'h88, d); chk("xfer enable", d, 16'h0000);
    rd(8'h89, d); chk("frame enable", d, 16'h0000);
    rd(8'h96, d); chk("group length", d, 16'h0101);
    rd(8'h8A, d); chk("unmapped", d, 16'h0000);
  endtask
  task automatic frame_flag_irq();
    logic [15:0] d;
    wr(8'h89, 16'h0001);
    wr(8'h87, 16'hFF7E);
    rd(8'h87, d); chk("armed flags", d, 16'h007E);
    wr(8'h87, 16'hFFFF);
    rd(8'h87, d); chk("flags after ones", d, 16'h007E);
    chk("irq idle", 16'(irq_o), 16'h0000);
    @(posedge sys_clk_i); ref_icp_sent_i <= 8'h81;
    @(posedge sys_clk_i); ref_icp_sent_i <= 8'h00;
    @(posedge sys_clk_i); @(negedge sys_clk_i);
    chk("irq frame", 16'(irq_o), 16'h0001);
    rd(8'h87, d); chk("flags after cell", d, 16'h00FF);
    wr(8'h87, 16'h00FE);
    @(posedge sys_clk_i); @(negedge sys_clk_i);
    chk("irq rearmed", 16'(irq_o), 16'h0000);
    @(posedge sys_clk_i);
    addr_i <= 8'h87;
    wdata_i <= 16'h00FD;
    wr_i <= 1'b1;
    ref_icp_sent_i <= 8'h02;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    ref_icp_sent_i <= 8'h00;
    rd(8'h87, d);
    chk("set beats arm", d, 16'h00FE);
    wr(8'h89, 16'h0000);
    wr(8'h87, 16'h00FF);
  endtask
  task automatic xfer_irq();
    logic [15:0] d;
    @(posedge sys_clk_i); xfer_done_i <= 8'h04; // group 2 only
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i); chk("irq masked", 16'(irq_o), 16'h0000);
    wr(8'h88, 16'hFF04);
    rd(8'h88, d); chk("xfer enable rd", d, 16'h0004);
    chk("irq xfer", 16'(irq_o), 16'h0001);
    wr(8'h88, 16'h0000);
    @(posedge sys_clk_i); @(negedge sys_clk_i);
    chk("irq disabled", 16'(irq_o), 16'h0000);
    @(posedge sys_clk_i);
    xfer_done_i <= 8'h00;
  endtask
  task automatic lengths();
    logic [15:0] d;
    // reserved bits 7:4 are written as zero, as software must
    for (int n = 0; n < 8; n++) wr(8'h8B + 8'(n), 16'hF000 | 16'(n << 8) | 16'(15 - n));
    for (int n = 0; n < 8; n++) begin
      rd(8'h8B + 8'(n), d);
      chk("link reg", d, 16'(n << 8) | 16'(15 - n));
      chk("link n", 16'(link_fifo_len_o[4*n +: 4]), 16'(15 - n));
      chk("link n8", 16'(link_fifo_len_o[4*(n+8) +: 4]), 16'(n));
    end
    wr(8'h94, 16'hFA05);
    rd(8'h94, d); chk("group reg", d, 16'h0A05);
    chk("group n", 16'(group_fifo_len_o[7:4]), 16'h0005);
    chk("group n4", 16'(group_fifo_len_o[23:20]), 16'h000A);
  endtask
  task automatic status_codes();
    logic [5:0] codes [7] = '{6'h00, 6'h0F, 6'h12, 6'h17, 6'h18, 6'h21, 6'h30};
    logic [15:0] d, e;
    foreach (codes[i]) begin
      wr(8'h9B, 16'hFFC0 | 16'(codes[i]));
      rd(8'h9B, d);
      if (codes[i] < 6'h10) e = 16'(codes[i]) + 16'h0001;
      else if (codes[i] < 6'h18) e = 16'(codes[i]);
      else if (codes[i] == 6'h18) e = 16'h0055;
      else if (codes[i] >= 6'h20 && codes[i] < 6'h30) e = 16'h003F - 16'(codes[i]);
      else e = 16'h0000;
      chk("status", d, e);
      chk("select", 16'(fifo_sel_o), 16'(codes[i]));
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    reset_values();
    frame_flag_irq();
    xfer_irq();
    lengths();
    status_codes();
    end_of_test();
  end
endmodule
